// ===== logic/holding_bank.sv
// Bank of holding registers that collect bytes for flash programming.
// Assumes the write strobe is a single-clock pulse from the table unit.
`timescale 1ns/1ps
`default_nettype none
module holding_bank #(
  parameter int N     = table_rw_pkg::HOLD_N,
  parameter int W     = table_rw_pkg::BYTE_W,
  parameter int SEL_W = table_rw_pkg::HSEL_W
) (
  input  wire logic           i_mclk,    // Quarter clock
  input  wire logic           i_resetn,  // Async reset, low
  input  wire logic           i_we,      // Write strobe
  input  wire logic [SEL_W-1:0] i_sel,   // Register select
  input  wire logic [W-1:0]   i_din,     // Byte to store
  output logic      [N*W-1:0] o_data     // All registers, reg 0 lowest
);

  // ******************************************
  // Registers
  // ******************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_hold
      logic [W-1:0] hold_ff;
      wire          hit = i_we && (i_sel == SEL_W'(g));

      // One holding byte, erased value after reset
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          hold_ff <= table_rw_pkg::HOLD_RST;
        end else if (hit) begin
          hold_ff <= i_din;
        end
      end
      assign o_data[g*W +: W] = hold_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== logic/table_rw_pkg.sv
// Constants shared by the table read/write unit and its holding bank.
// Assumes one 250 MHz clock; each clock is one quarter of an instruction cycle.
package table_rw_pkg;

  // ******************************************
  // Widths
  // ******************************************
  localparam int PTR_W   = 21;
  localparam int BYTE_W  = 8;
  localparam int WORD_W  = 16;
  localparam int FADDR_W = 20;
  localparam int HOLD_N  = 8;
  localparam int HSEL_W  = 3;
  localparam int OP_W    = 16;
  localparam int MODE_W  = 2;
  localparam int QTR_W   = 2;
  localparam int REG_AW  = 4;
  localparam int BUS_W   = 32;
  localparam int BE_W    = 4;
  localparam int HALF_BIT = 0;

  // ******************************************
  // Opcodes and pointer modes
  // ******************************************
  localparam logic [OP_W-1:0]   OP_CLASS_MASK = 16'hfffc;
  localparam logic [OP_W-1:0]   OP_READ_BASE  = 16'h0008;
  localparam logic [OP_W-1:0]   OP_WRITE_BASE = 16'h000c;
  localparam logic [OP_W-1:0]   OPCODE_RST    = 16'h0000;
  localparam int                OP_DIR_BIT    = 2;
  localparam logic [MODE_W-1:0] MODE_KEEP     = 2'h0;
  localparam logic [MODE_W-1:0] MODE_POST_INC = 2'h1;
  localparam logic [MODE_W-1:0] MODE_POST_DEC = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PRE_INC  = 2'h3;

  // ******************************************
  // Quarter phases and reset values
  // ******************************************
  localparam logic [QTR_W-1:0]  QTR_1 = 2'h0;
  localparam logic [QTR_W-1:0]  QTR_2 = 2'h1;
  localparam logic [QTR_W-1:0]  QTR_3 = 2'h2;
  localparam logic [QTR_W-1:0]  QTR_4 = 2'h3;
  localparam logic [PTR_W-1:0]  PTR_STEP  = 21'h000001;
  localparam logic [PTR_W-1:0]  PTR_RST   = 21'h000000;
  localparam logic [BYTE_W-1:0] LATCH_RST = 8'h00;
  localparam logic [BYTE_W-1:0] HOLD_RST  = 8'hff;

  // ******************************************
  // Register word indices and status fields
  // ******************************************
  localparam logic [REG_AW-1:0] REG_PTR    = 4'h0;
  localparam logic [REG_AW-1:0] REG_LATCH  = 4'h1;
  localparam logic [REG_AW-1:0] REG_CMD    = 4'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
  localparam int                REG_HOLD_BIT = 3;
  localparam int                ST_BUSY_BIT  = 0;
  localparam int                ST_PEND_BIT  = 1;
  localparam int                ST_WRITE_BIT = 2;
  localparam int                ST_MODE_LSB  = 3;
  localparam int                ST_USED_W    = 5;

endpackage

// ===== logic/table_rw_unit.sv
// Table read/write unit: moves bytes from program flash into the latch,
// and from the latch into the holding registers.
// Assumes the core presents opcodes in quarter 1 and flash data comes one
// clock after the read strobe.
// Contract
// RULE1: table read puts the flash byte at the pointer into the latch
// RULE2: pointer is 21 bits, one address per byte, 2 Mbyte space
// RULE3: pointer bit 0 picks low (0) or high (1) byte of a word
// RULE4: read opcode low bits: keep, post-inc, post-dec, pre-inc
// RULE5: table write copies latch to holding register chosen by pointer bits 2:0
// RULE6: holding registers feed flash programming; a table write never touches flash
// RULE7: write opcode low bits use the same four pointer modes
// RULE8: no-change write stores the byte and leaves the pointer untouched
// RULE9: post modes adjust after the store; pre-inc adjusts before it
// RULE10: write takes two cycles; latch read in Q2, store in Q4
// RULE11: read takes two cycles; flash access Q2, latch update Q4
`timescale 1ns/1ps
`default_nettype none
module table_rw_unit #(
  parameter int PTR_W = table_rw_pkg::PTR_W,
  parameter int HOLD_N = table_rw_pkg::HOLD_N
) (
  input  wire logic                     i_mclk,            // Quarter clock
  input  wire logic                     i_resetn,          // Async reset, low
  input  wire logic                     i_op_valid,        // Core opcode present
  input  wire logic [table_rw_pkg::OP_W-1:0] i_opcode,     // Core opcode
  output logic                          o_op_ready,        // Idle in quarter 1; a table opcode is taken this clock
  output logic                          o_busy,            // Operation running
  output logic [table_rw_pkg::QTR_W-1:0] o_quarter,        // Current quarter
  output logic                          o_flash_rd,        // Flash read strobe
  output logic [table_rw_pkg::FADDR_W-1:0] o_flash_addr,   // Flash word address
  input  wire logic [table_rw_pkg::WORD_W-1:0] i_flash_word, // Flash word
  output logic [PTR_W-1:0]              o_table_pointer,   // Pointer value
  output logic [table_rw_pkg::BYTE_W-1:0] o_table_latch,   // Latch value
  output logic [HOLD_N*table_rw_pkg::BYTE_W-1:0] o_hold_data, // To programmer
  input  wire logic [table_rw_pkg::REG_AW-1:0] i_avs_address, // Word index
  input  wire logic                     i_avs_read,        // Bus read
  input  wire logic                     i_avs_write,       // Bus write
  input  wire logic [table_rw_pkg::BUS_W-1:0] i_avs_writedata, // Write data
  input  wire logic [table_rw_pkg::BE_W-1:0] i_avs_byteenable, // Byte lanes
  output logic [table_rw_pkg::BUS_W-1:0] o_avs_readdata,   // Read data
  output logic                          o_avs_waitrequest  // Stall
);

  localparam int BW = table_rw_pkg::BYTE_W;
  localparam int DW = table_rw_pkg::BUS_W;
  localparam int OW = table_rw_pkg::OP_W;
  localparam int MW = table_rw_pkg::MODE_W;

  typedef enum logic [1:0] {ST_IDLE, ST_CYC1, ST_CYC2} op_state_t;

  // ******************************************
  // Functions
  // ******************************************
  // Opcode is a table read or table write
  function automatic logic is_table_op(input logic [OW-1:0] op);
    logic [OW-1:0] cls;
    cls = op & table_rw_pkg::OP_CLASS_MASK;
    return (cls == table_rw_pkg::OP_READ_BASE) ||
           (cls == table_rw_pkg::OP_WRITE_BASE);
  endfunction

  // Merge write data into old word by byte lane
  function automatic logic [DW-1:0] merge_be(input logic [DW-1:0] old_w,
                                             input logic [DW-1:0] new_w,
                                             input logic [table_rw_pkg::BE_W-1:0] be);
    logic [DW-1:0] res;
    res = old_w;
    for (int b = 0; b < table_rw_pkg::BE_W; b++) begin
      if (be[b]) begin
        res[b*BW +: BW] = new_w[b*BW +: BW];
      end
    end
    return res;
  endfunction

  // ******************************************
  // State
  // ******************************************
  op_state_t         state_ff, nxt_state;
  logic [1:0]        qtr_ff;
  logic              dir_ff;
  logic [MW-1:0]     mode_ff;
  logic [PTR_W-1:0]  ptr_ff, nxt_ptr;
  logic [BW-1:0]     latch_ff, nxt_latch;
  logic [BW-1:0]     xfer_ff, nxt_xfer;
  logic [OW-1:0]     sw_op_ff;
  logic              sw_pend_ff, nxt_sw_pend;
  logic [PTR_W-1:0]  ptr_at_start_ff;
  logic              ack_ff;
  logic [DW-1:0]     rdata_ff;

  // ******************************************
  // Operation decode
  // ******************************************
  wire            core_go   = i_op_valid && is_table_op(i_opcode);
  wire            idle_q1   = (state_ff == ST_IDLE) && (qtr_ff == table_rw_pkg::QTR_1);
  wire            start_core = idle_q1 && core_go;
  wire            start_sw  = idle_q1 && !core_go && sw_pend_ff;
  wire            start     = start_core || start_sw;
  wire [OW-1:0]   start_op  = start_core ? i_opcode : sw_op_ff;
  wire            cyc1_q4   = (state_ff == ST_CYC1) && (qtr_ff == table_rw_pkg::QTR_4);
  wire            c2_q2     = (state_ff == ST_CYC2) && (qtr_ff == table_rw_pkg::QTR_2);
  wire            c2_q3     = (state_ff == ST_CYC2) && (qtr_ff == table_rw_pkg::QTR_3);
  wire            c2_q4     = (state_ff == ST_CYC2) && (qtr_ff == table_rw_pkg::QTR_4);

  // Pointer adjust: pre-inc in cycle 1, post modes at end of cycle 2
  wire pre_step  = cyc1_q4 && (mode_ff == table_rw_pkg::MODE_PRE_INC);     // RULE9
  wire post_step = c2_q4 && ((mode_ff == table_rw_pkg::MODE_POST_INC) ||
                             (mode_ff == table_rw_pkg::MODE_POST_DEC));   // RULE9
  wire [PTR_W-1:0] ptr_adj = (mode_ff == table_rw_pkg::MODE_POST_DEC) ?
                             ptr_ff - table_rw_pkg::PTR_STEP :
                             ptr_ff + table_rw_pkg::PTR_STEP;             // RULE4 RULE7

  // Byte pick within the flash word
  wire [BW-1:0] flash_byte = ptr_ff[table_rw_pkg::HALF_BIT] ?
                             i_flash_word[BW +: BW] : i_flash_word[0 +: BW]; // RULE3

  // Holding register write at Q4 of cycle 2
  wire hold_we = c2_q4 && dir_ff;                                           // RULE10
  wire [table_rw_pkg::HSEL_W-1:0] hold_sel = ptr_ff[table_rw_pkg::HSEL_W-1:0]; // RULE5

  // ******************************************
  // Bus decode
  // ******************************************
  wire            bus_req  = i_avs_read || i_avs_write;
  wire            bus_take = bus_req && !ack_ff && (state_ff == ST_IDLE) && !start;
  wire            wr_done  = i_avs_write && ack_ff;
  wire            wr_ptr   = wr_done && (i_avs_address == table_rw_pkg::REG_PTR);
  wire            wr_latch = wr_done && (i_avs_address == table_rw_pkg::REG_LATCH);
  wire            wr_cmd   = wr_done && (i_avs_address == table_rw_pkg::REG_CMD);
  wire [DW-1:0]   ptr_word = {{(DW-PTR_W){1'b0}}, ptr_ff};
  wire [DW-1:0]   lat_word = {{(DW-BW){1'b0}}, latch_ff};
  wire [DW-1:0]   cmd_word = {{(DW-OW){1'b0}}, sw_op_ff};
  wire [DW-1:0]   ptr_new  = merge_be(ptr_word, i_avs_writedata, i_avs_byteenable);
  wire [DW-1:0]   lat_new  = merge_be(lat_word, i_avs_writedata, i_avs_byteenable);
  wire [DW-1:0]   cmd_new  = merge_be(cmd_word, i_avs_writedata, i_avs_byteenable);
  wire            cmd_ok   = wr_cmd && is_table_op(cmd_new[OW-1:0]);
  wire [table_rw_pkg::ST_USED_W-1:0] status_bits = {mode_ff, dir_ff, sw_pend_ff,
                                                    (state_ff != ST_IDLE)};
  wire [BW-1:0]   hold_rd  = o_hold_data[{i_avs_address[table_rw_pkg::HSEL_W-1:0],
                                          3'h0} +: BW];

  // Read data select, unmapped words read as zero
  wire [DW-1:0]   rd_mux =
      i_avs_address[table_rw_pkg::REG_HOLD_BIT] ? {{(DW-BW){1'b0}}, hold_rd} :
      (i_avs_address == table_rw_pkg::REG_PTR)    ? ptr_word :
      (i_avs_address == table_rw_pkg::REG_LATCH)  ? lat_word :
      (i_avs_address == table_rw_pkg::REG_CMD)    ? cmd_word :
      (i_avs_address == table_rw_pkg::REG_STATUS) ?
          {{(DW-table_rw_pkg::ST_USED_W){1'b0}}, status_bits} : '0;

  // ******************************************
  // Next-state logic
  // ******************************************
  // Two instruction cycles per operation
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (start) nxt_state = ST_CYC1;
      ST_CYC1: if (cyc1_q4) nxt_state = ST_CYC2;                          // RULE10 RULE11
      ST_CYC2: if (c2_q4) nxt_state = ST_IDLE;                            // RULE10 RULE11
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Pointer: bus write, or mode step; keep mode holds its value
  assign nxt_ptr = wr_ptr ? ptr_new[PTR_W-1:0] :
                   (pre_step || post_step) ? ptr_adj : ptr_ff;              // RULE2 RULE8

  // Latch: bus write, or flash byte at end of a read
  assign nxt_latch = wr_latch ? lat_new[BW-1:0] :
                     (c2_q4 && !dir_ff) ? xfer_ff : latch_ff;              // RULE1 RULE11

  // Transfer byte: latch in Q2 for a write, flash byte in Q3 for a read
  assign nxt_xfer = (c2_q2 && dir_ff)  ? latch_ff :                         // RULE10
                    (c2_q3 && !dir_ff) ? flash_byte : xfer_ff;              // RULE1

  // Software command pending; a new command wins over the clear
  assign nxt_sw_pend = (sw_pend_ff && !start_sw) || cmd_ok;

  // ******************************************
  // Registers
  // ******************************************
  // Quarter counter and operation state
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      qtr_ff   <= table_rw_pkg::QTR_1;
      state_ff <= ST_IDLE;
    end else begin
      qtr_ff   <= qtr_ff + 2'h1;
      state_ff <= nxt_state;
    end
  end

  // Captured opcode fields
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_ff          <= 1'b0;
      mode_ff         <= table_rw_pkg::MODE_KEEP;
      ptr_at_start_ff <= table_rw_pkg::PTR_RST;
    end else if (start) begin
      dir_ff          <= start_op[table_rw_pkg::OP_DIR_BIT];
      mode_ff         <= start_op[MW-1:0];                                  // RULE4 RULE7
      ptr_at_start_ff <= nxt_ptr;                                           // Bus write landing now
    end
  end

  // Data path registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_ff   <= table_rw_pkg::PTR_RST;
      latch_ff <= table_rw_pkg::LATCH_RST;
      xfer_ff  <= table_rw_pkg::LATCH_RST;
    end else begin
      ptr_ff   <= nxt_ptr;
      latch_ff <= nxt_latch;
      xfer_ff  <= nxt_xfer;
    end
  end

  // Bus slave and software command
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_ff     <= 1'b0;
      rdata_ff   <= '0;
      sw_op_ff   <= table_rw_pkg::OPCODE_RST;
      sw_pend_ff <= 1'b0;
    end else begin
      ack_ff     <= bus_take;
      if (bus_take) rdata_ff <= rd_mux;
      if (cmd_ok) sw_op_ff <= cmd_new[OW-1:0];
      sw_pend_ff <= nxt_sw_pend;
    end
  end

  // ******************************************
  // Holding registers
  // ******************************************
  holding_bank #(
    .N     (HOLD_N),
    .W     (BW),
    .SEL_W (table_rw_pkg::HSEL_W)
  ) u_hold (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_we     (hold_we),
    .i_sel    (hold_sel),
    .i_din    (xfer_ff),
    .o_data   (o_hold_data)                                                // RULE6
  );

  // ******************************************
  // Outputs
  // ******************************************
  assign o_op_ready        = idle_q1;
  assign o_busy            = (state_ff != ST_IDLE);
  assign o_quarter         = qtr_ff;
  assign o_flash_rd        = c2_q2 && !dir_ff;                              // RULE11
  assign o_flash_addr      = ptr_ff[PTR_W-1:1];                             // RULE2
  assign o_table_pointer   = ptr_ff;
  assign o_table_latch     = latch_ff;
  assign o_avs_readdata    = rdata_ff;
  assign o_avs_waitrequest = !ack_ff;

  // ******************************************
  // Assertions
  // ******************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  wire [PTR_W-1:0] ptr_plus  = ptr_at_start_ff + table_rw_pkg::PTR_STEP;
  wire [PTR_W-1:0] ptr_minus = ptr_at_start_ff - table_rw_pkg::PTR_STEP;
  wire [PTR_W-1:0] exp_ptr =
      (mode_ff == table_rw_pkg::MODE_PRE_INC) ? ptr_plus : ptr_at_start_ff;
  wire [table_rw_pkg::HSEL_W-1:0] exp_sel = exp_ptr[table_rw_pkg::HSEL_W-1:0];
  wire [BW-1:0] exp_hold = o_hold_data[{exp_sel, 3'h0} +: BW];

  property p_read_latch;
    o_flash_rd |-> ##3 (o_table_latch == ($past(ptr_ff[table_rw_pkg::HALF_BIT], 2) ?
        $past(i_flash_word[BW +: BW], 2) : $past(i_flash_word[0 +: BW], 2)));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch missed flash byte"); // RULE1

  property p_flash_addr;
    o_flash_rd |-> (o_flash_addr == exp_ptr[PTR_W-1:1]);
  endproperty
  a_flash_addr: assert property (p_flash_addr) else $error("flash address wrong"); // RULE2

  property p_byte_pick;
    (o_flash_rd && o_table_pointer[table_rw_pkg::HALF_BIT]) |-> ##2
      (xfer_ff == $past(i_flash_word[BW +: BW]));
  endproperty
  a_byte_pick: assert property (p_byte_pick) else $error("high byte not picked"); // RULE3

  property p_read_dec;
    (c2_q4 && !dir_ff && mode_ff == table_rw_pkg::MODE_POST_DEC) |=>
      (o_table_pointer == $past(ptr_minus));
  endproperty
  a_read_dec: assert property (p_read_dec) else $error("read post-dec wrong"); // RULE4

  property p_hold_sel;
    hold_we |=> (exp_hold == $past(latch_ff, 3));
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("holding byte wrong"); // RULE5

  property p_hold_quiet;
    !hold_we |=> $stable(o_hold_data);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("holding changed"); // RULE6

  property p_write_pre;
    (hold_we && mode_ff == table_rw_pkg::MODE_PRE_INC) |->
      (ptr_ff == ptr_plus) ##1 (o_table_pointer == $past(ptr_plus));
  endproperty
  a_write_pre: assert property (p_write_pre) else $error("pre-inc write wrong"); // RULE7

  property p_write_keep;
    (c2_q4 && dir_ff && mode_ff == table_rw_pkg::MODE_KEEP) |=>
      (o_table_pointer == $past(ptr_at_start_ff));
  endproperty
  a_write_keep: assert property (p_write_keep) else $error("pointer moved"); // RULE8

  property p_post_inc;
    (c2_q4 && mode_ff == table_rw_pkg::MODE_POST_INC) |->
      (ptr_ff == ptr_at_start_ff) ##1 (o_table_pointer == $past(ptr_plus));
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-inc wrong"); // RULE9

  property p_write_len;
    (start && start_op[table_rw_pkg::OP_DIR_BIT]) |=>
      o_busy[*7] ##1 !o_busy;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write length wrong"); // RULE10

  property p_read_len;
    (start && !start_op[table_rw_pkg::OP_DIR_BIT]) |-> ##5 o_flash_rd;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe late"); // RULE11

  c_read_pre: cover property (start && !start_op[table_rw_pkg::OP_DIR_BIT] &&
                              start_op[MW-1:0] == table_rw_pkg::MODE_PRE_INC);
  c_write_dec: cover property (hold_we && mode_ff == table_rw_pkg::MODE_POST_DEC);
  c_bus_read: cover property (i_avs_read && !o_avs_waitrequest);
  c_sw_start: cover property (start_sw);

endmodule
`default_nettype wire

// ===== verif/flash_model.sv
// Program flash partner: answers a read strobe with one word a clock later.
// Assumes a one-clock strobe and a word address from the table unit.
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic        i_mclk,  // Quarter clock
  input  wire logic        i_rd,    // Read strobe
  input  wire logic [19:0] i_addr,  // Word address
  output logic      [15:0] o_word   // Word to unit
);
  // ****************************************
  // Read port only, contents never written
  // ****************************************
  // Word is valid one clock after the strobe, then toggles so stale data fails
  always @(posedge i_mclk) begin
    if (i_rd) begin
      o_word <= {i_addr[7:0] ^ 8'ha5, i_addr[15:8] ^ i_addr[19:12]};
    end else begin
      o_word <= ~o_word;
    end
  end
  // Arbitrary start pattern
  initial o_word = 16'h5a5a;
endmodule
`default_nettype wire

// ===== verif/tb_table_rw_unit.sv
// Self-checking bench: core ops and bus traffic against a mirror model.
// Assumes the design package and the flash model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_table_rw_unit;
  typedef struct {logic [20:0] p; logic [7:0] l; logic [63:0] h;
                  logic [19:0] fa; logic w;} exp_t;
  logic        i_mclk = 1'b0, i_resetn = 1'b0, i_op_valid = 1'b0;
  logic        i_avs_read = 1'b0, i_avs_write = 1'b0, op_ready, busy, flash_rd, wreq;
  logic        bsy_d = 1'b0;
  logic [15:0] i_opcode = 16'h0000, fword;
  logic [1:0]  quarter;
  logic [19:0] faddr;
  logic [20:0] ptr, ptr_m = 21'h0;
  logic [7:0]  lat, lat_m = 8'h00;
  logic [63:0] hold, hold_m = {8{8'hff}};
  logic [3:0]  i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, rdata;
  exp_t        opq[$];
  logic [31:0] rdq[$];
  int          fails = 0, checked = 0, qn = 0;
  // ****************************************
  // Harness
  // ****************************************
  table_rw_unit table_rw_unit_i (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_op_valid(i_op_valid), .i_opcode(i_opcode),
    .o_op_ready(op_ready), .o_busy(busy), .o_quarter(quarter), .o_flash_rd(flash_rd),
    .o_flash_addr(faddr), .i_flash_word(fword), .o_table_pointer(ptr),
    .o_table_latch(lat), .o_hold_data(hold), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
  flash_model flash_model_i (.i_mclk(i_mclk), .i_rd(flash_rd), .i_addr(faddr),
    .o_word(fword));
  // Quarter clock
  initial begin
    forever #2 i_mclk = ~i_mclk;
  end
  // Mirror of one operation, queued for the monitor
  task automatic exp_op(input logic w, input logic [1:0] m);
    logic [19:0] fa;
    logic [15:0] wd;
    if (m == 2'h3) ptr_m = ptr_m + 21'h1;
    fa = ptr_m[20:1];
    wd = {fa[7:0] ^ 8'ha5, fa[15:8] ^ fa[19:12]};
    if (w) hold_m[8*ptr_m[2:0] +: 8] = lat_m;
    else lat_m = ptr_m[0] ? wd[15:8] : wd[7:0];
    if (m == 2'h1) ptr_m = ptr_m + 21'h1;
    if (m == 2'h2) ptr_m = ptr_m - 21'h1;
    opq.push_back('{ptr_m, lat_m, hold_m, fa, w});
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_mclk);
    end while (wreq !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (w && a == 4'h0) ptr_m = d[20:0];
    if (w && a == 4'h1) lat_m = d[7:0];
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Core opcode, held until the unit takes it
  task automatic op(input logic w, input logic [1:0] m);
    exp_op(w, m);
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_opcode <= {12'h000, 1'b1, w, m};
    do begin
      @(posedge i_mclk);
    end while (op_ready !== 1'b1);
    i_op_valid <= 1'b0;
  endtask
  task automatic done(input string s);
    $display("test %s done, %0d checks", s, checked);
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Monitor: flash strobe, op completion and bus read data against the notes
  always @(posedge i_mclk) begin
    if (flash_rd && opq.size() > 0) begin
      `CHK({quarter, faddr, opq[0].w}, {table_rw_pkg::QTR_2, opq[0].fa, 1'b0})
    end
    if (bsy_d && !busy && opq.size() > 0) begin
      `CHK({qn, ptr, lat, hold}, {32'd7, opq[0].p, opq[0].l, opq[0].h})
      void'(opq.pop_front());
    end
    if (i_avs_read && !wreq && rdq.size() > 0) begin
      `CHK(rdata, rdq[0])
      void'(rdq.pop_front());
    end
    qn = busy ? qn + 1 : 0;
    bsy_d = busy;
  end
  // Watchdog
  initial begin
    #200000;
    fails++;
    results();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [1:0] m;
    logic       w;
    void'($urandom(32'he284));
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h0);
    for (int i = 8; i < 16; i++) rd(4'(i), 32'hff);
    bus(1'b1, 4'h5, 32'hffffffff);
    rd(4'h5, 32'h0);
    done("reset");
    bus(1'b1, 4'h0, 32'hffffffff);
    rd(4'h0, 32'h001fffff);
    op(1'b0, 2'h1);
    op(1'b0, 2'h2);
    done("wrap");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, $urandom);
      bus(1'b1, 4'h1, $urandom);
      op(i[2], i[1:0]);
      rd(4'h1, {24'h0, lat_m});
      rd(4'h0, {11'h0, ptr_m});
    end
    done("modes");
    for (int i = 0; i < 24; i++) begin
      m = 2'($urandom);
      w = 1'($urandom);
      op(w, m);
    end
    for (int i = 8; i < 16; i++) rd(4'(i), {24'h0, hold_m[8*(i-8) +: 8]});
    done("burst");
    exp_op(1'b0, 2'h3);
    bus(1'b1, 4'h2, 32'h0000000b);
    for (int k = 0; k < 40 && opq.size() > 0; k++) @(posedge i_mclk);
    rd(4'h0, {11'h0, ptr_m});
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_opcode <= 16'h0010;
    repeat (12) @(negedge i_mclk);
    `CHK(busy, 1'b0)
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    rd(4'h0, {11'h0, ptr_m});
    rd(4'h3, 32'h00000018);
    rd(4'h2, 32'h0000000b);
    done("command");
    results();
  end
endmodule
`default_nettype wire
